// ==== hdl/ear_autorange.sv ====
// Functional notes
// - comparator flags are only acted on while filament and autorange are on
// - above 117% step less sensitive, below 9.5% step more sensitive
// - at most one range step per ranging tick of about 0.35 s
// - decode counter state into switch and converter controls
// - decoded range drives three separate decade select switches
// - counter saturates between the 1e-8 and 1e-4 decades
// - reset forces the counter to its initial state before ranging
// - with autorange off, only manual up or down requests change range
// - pressure output flagged invalid when filament or autorange is off
`timescale 1ns/1ns
module ear_autorange #(
    parameter int unsigned TICK_CYCLES = ear_pkg::TICK_CYCLES
) (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       filament_on,
    input  wire logic                       autorange_on,
    input  wire logic                       over_range_comparator,
    input  wire logic                       under_range_comparator,
    input  wire logic                       manual_range_up,
    input  wire logic                       manual_range_down,
    input  wire logic [ear_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ear_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [ear_pkg::DATA_W-1:0] reg_rdata,
    output logic                            decade_switch_a,
    output logic                            decade_switch_b,
    output logic                            decade_switch_c,
    output logic                            divide_by_ten,
    output logic      [ear_pkg::RANGE_W-1:0] conv_decade,
    output logic                            pressure_valid,
    output logic                            pressure_force_low
);
    import ear_pkg::*;

    generate
        if (TICK_CYCLES < 2) begin : g_bad_tick
            $error("TICK_CYCLES must be at least two");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SYN_W-1:0] sync1_ff;
    logic [SYN_W-1:0] sync2_ff;
    logic [1:0]       man_prev_ff;
    logic [SYN_W-1:0] nxt_sync1;
    logic [SYN_W-1:0] nxt_sync2;
    logic [1:0]       nxt_man_prev;

    always_comb begin
        nxt_sync1[SYN_FIL] = filament_on;
        nxt_sync1[SYN_AUT] = autorange_on;
        nxt_sync1[SYN_OVR] = over_range_comparator;
        nxt_sync1[SYN_UND] = under_range_comparator;
        nxt_sync1[SYN_MUP] = manual_range_up;
        nxt_sync1[SYN_MDN] = manual_range_down;
        nxt_sync2          = sync1_ff;
        nxt_man_prev       = {sync2_ff[SYN_MDN], sync2_ff[SYN_MUP]};
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            man_prev_ff <= '0;
        end else begin
            sync1_ff    <= nxt_sync1;
            sync2_ff    <= nxt_sync2;
            man_prev_ff <= nxt_man_prev;
        end
    end

    logic fil_s;
    logic auto_s;
    logic over_s;
    logic under_s;
    logic auto_en;
    logic man_up_edge;
    logic man_dn_edge;

    assign fil_s       = sync2_ff[SYN_FIL];
    assign auto_s      = sync2_ff[SYN_AUT];
    assign over_s      = sync2_ff[SYN_OVR];
    assign under_s     = sync2_ff[SYN_UND];
    assign auto_en     = fil_s & auto_s;
    assign man_up_edge = sync2_ff[SYN_MUP] & ~man_prev_ff[0];
    assign man_dn_edge = sync2_ff[SYN_MDN] & ~man_prev_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // ranging clock
    logic tick;

    ear_tick_gen #(
        .PERIOD (TICK_CYCLES)
    ) u_ranging_tick_osc (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tick_o   (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // register port
    logic              hold_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              nxt_hold;
    logic [DATA_W-1:0] nxt_rdata;
    logic              sw_up;
    logic              sw_dn;
    logic [2:0]        range_updown_counter_ff;

    assign sw_up = reg_wr && (reg_addr == REG_STEP) && reg_wdata[STEP_UP_BIT];
    assign sw_dn = reg_wr && (reg_addr == REG_STEP) && reg_wdata[STEP_DN_BIT];

    always_comb begin
        nxt_hold  = hold_ff;
        nxt_rdata = '0;
        if (reg_wr && reg_addr == REG_CTRL) begin
            nxt_hold = reg_wdata[CTRL_HOLD_BIT];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: begin
                    nxt_rdata[ST_RANGE_LSB +: RANGE_W] =
                        range_updown_counter_ff;
                    nxt_rdata[ST_VALID_BIT] = pressure_valid;
                    nxt_rdata[ST_FIL_BIT]   = fil_s;
                    nxt_rdata[ST_AUTO_BIT]  = auto_s;
                    nxt_rdata[ST_HOLD_BIT]  = hold_ff;
                end
                REG_CTRL: nxt_rdata[CTRL_HOLD_BIT] = hold_ff;
                default:  nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_ff  <= CTRL_HOLD_RST;
            rdata_ff <= '0;
        end else begin
            hold_ff  <= nxt_hold;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // manual requests wait for the next tick so the pacing stays uniform
    logic pend_up_ff;
    logic pend_dn_ff;
    logic nxt_pend_up;
    logic nxt_pend_dn;

    always_comb begin
        nxt_pend_up = pend_up_ff;
        nxt_pend_dn = pend_dn_ff;
        if (tick) begin
            nxt_pend_up = 1'b0;
            nxt_pend_dn = 1'b0;
        end
        // a request arriving on the consuming tick is kept, not lost
        if (man_up_edge || sw_up) begin
            nxt_pend_up = 1'b1;
        end
        if (man_dn_edge || sw_dn) begin
            nxt_pend_dn = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pend_up_ff <= 1'b0;
            pend_dn_ff <= 1'b0;
        end else begin
            pend_up_ff <= nxt_pend_up;
            pend_dn_ff <= nxt_pend_dn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // range counter
    logic       step_up;
    logic       step_dn;
    logic [2:0] nxt_range;

    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (tick) begin
            if (auto_en && !hold_ff) begin
                // over wins if both flags glitch high together
                step_up = over_s;
                step_dn = under_s && !over_s;
            end else if (!auto_s) begin
                step_up = pend_up_ff;
                step_dn = pend_dn_ff && !pend_up_ff;
            end
        end
        nxt_range = range_updown_counter_ff;
        if (step_up && range_updown_counter_ff < RANGE_MAX) begin
            nxt_range = range_updown_counter_ff + 3'h1;
        end else if (step_dn
                     && range_updown_counter_ff > RANGE_MIN) begin
            nxt_range = range_updown_counter_ff - 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            range_updown_counter_ff <= RANGE_RST;
        end else begin
            range_updown_counter_ff <= nxt_range;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded outputs, registered one cycle behind the counter
    logic [3:0] dec_ff;
    logic [2:0] conv_ff;
    logic       valid_ff;
    logic       force_ff;
    logic [3:0] nxt_dec;
    logic [2:0] nxt_conv;
    logic       nxt_valid;
    logic       nxt_force;

    always_comb begin
        nxt_dec   = ear_decode(range_updown_counter_ff);
        nxt_conv  = range_updown_counter_ff;
        nxt_valid = auto_en;
        nxt_force = !auto_en;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dec_ff   <= DEC_R0;
            conv_ff  <= RANGE_RST;
            valid_ff <= 1'b0;
            force_ff <= 1'b1;
        end else begin
            dec_ff   <= nxt_dec;
            conv_ff  <= nxt_conv;
            valid_ff <= nxt_valid;
            force_ff <= nxt_force;
        end
    end

    assign decade_switch_a    = dec_ff[0];
    assign decade_switch_b    = dec_ff[1];
    assign decade_switch_c    = dec_ff[2];
    assign divide_by_ten      = dec_ff[3];
    assign conv_decade        = conv_ff;
    assign pressure_valid     = valid_ff;
    assign pressure_force_low = force_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    auto_gate_a: assert property (
        !auto_en && auto_s |=> $stable(range_updown_counter_ff))
        else $error("ranging stepped while gated off");

    over_step_a: assert property (
        tick && auto_en && !hold_ff && over_s
            && range_updown_counter_ff < RANGE_MAX
        |=> range_updown_counter_ff == $past(range_updown_counter_ff) + 3'h1)
        else $error("over-range did not step up");

    under_step_a: assert property (
        tick && auto_en && !hold_ff && under_s && !over_s
            && range_updown_counter_ff > RANGE_MIN
        |=> range_updown_counter_ff == $past(range_updown_counter_ff) - 3'h1)
        else $error("under-range did not step down");

    tick_pace_a: assert property (
        !$stable(range_updown_counter_ff) && !$past(sys_rst) |-> $past(tick))
        else $error("range changed without a tick");

    switch_decode_a: assert property (
        ##1 {divide_by_ten, decade_switch_c, decade_switch_b, decade_switch_a}
            == ear_decode($past(range_updown_counter_ff))
        and $onehot({decade_switch_c, decade_switch_b, decade_switch_a}))
        else $error("decade switches disagree with counter");

    range_bound_a: assert property (
        range_updown_counter_ff <= RANGE_MAX)
        else $error("range counter out of bounds");

    reset_init_a: assert property (
        $fell(sys_rst) |-> range_updown_counter_ff == RANGE_RST
            && !pressure_valid && pressure_force_low)
        else $error("reset did not initialise range");

    manual_only_a: assert property (
        tick && !auto_s && !pend_up_ff && !pend_dn_ff
        |=> $stable(range_updown_counter_ff))
        else $error("manual mode changed range without request");

    invalid_out_a: assert property (
        !auto_en |=> !pressure_valid && pressure_force_low)
        else $error("pressure output not flagged invalid");

    hold_window_a: assert property (
        !step_up && !step_dn |=> $stable(range_updown_counter_ff))
        else $error("range moved with no step request");

endmodule : ear_autorange

// ==== shared/ear_pkg.sv ====
package ear_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_FREQ_HZ     = 10_000_000;
    // ranging tick period, middle of the 0.3 .. 0.4 s band
    localparam int TICK_PERIOD_MS  = 350;
    localparam int TICK_CYCLES     = TICK_PERIOD_MS * (CLK_FREQ_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////
    // range counter: code 0 is the 1e-8 decade, code 4 the 1e-4 decade
    localparam int       RANGE_W   = 3;
    localparam logic [2:0] RANGE_MIN = 3'h0;
    localparam logic [2:0] RANGE_MAX = 3'h4;
    localparam logic [2:0] RANGE_RST = 3'h0;

    // comparator thresholds, per mille of full scale (full scale = 10.0)
    localparam int OVER_PERMILLE   = 1170;
    localparam int UNDER_PERMILLE  = 95;
    localparam int FULL_SCALE_X10  = 100;

    ////////////////////////////////////////////////////////////////////////
    // synchroniser bit positions
    localparam int SYN_W   = 6;
    localparam int SYN_FIL = 0;
    localparam int SYN_AUT = 1;
    localparam int SYN_OVR = 2;
    localparam int SYN_UND = 3;
    localparam int SYN_MUP = 4;
    localparam int SYN_MDN = 5;

    ////////////////////////////////////////////////////////////////////////
    // register port
    localparam int         ADDR_W     = 4;
    localparam int         DATA_W     = 8;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CTRL   = 4'h4;
    localparam logic [3:0] REG_STEP   = 4'h8;

    localparam int ST_RANGE_LSB = 0;
    localparam int ST_VALID_BIT = 3;
    localparam int ST_FIL_BIT   = 4;
    localparam int ST_AUTO_BIT  = 5;
    localparam int ST_HOLD_BIT  = 6;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int STEP_UP_BIT   = 0;
    localparam int STEP_DN_BIT   = 1;
    localparam logic CTRL_HOLD_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // switch decode: {divide_by_ten, switch_c, switch_b, switch_a}
    localparam logic [3:0] DEC_R0   = 4'h1;
    localparam logic [3:0] DEC_R1   = 4'h9;
    localparam logic [3:0] DEC_R2   = 4'h2;
    localparam logic [3:0] DEC_R3   = 4'hA;
    localparam logic [3:0] DEC_R4   = 4'h4;
    localparam logic [3:0] DEC_NONE = 4'h0;

    function automatic logic [3:0] ear_decode(input logic [2:0] r);
        logic [3:0] d;
        unique case (r)
            3'h0:    d = DEC_R0;
            3'h1:    d = DEC_R1;
            3'h2:    d = DEC_R2;
            3'h3:    d = DEC_R3;
            3'h4:    d = DEC_R4;
            default: d = DEC_NONE;
        endcase
        return d;
    endfunction : ear_decode

endpackage : ear_pkg

// ==== hdl/ear_tick_gen.sv ====
`timescale 1ns/1ns
module ear_tick_gen #(
    parameter int unsigned PERIOD = ear_pkg::TICK_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    output logic      tick_o
);
    import ear_pkg::*;

    localparam int CNT_W = (PERIOD > 2) ? $clog2(PERIOD) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

    generate
        if (PERIOD < 2) begin : g_bad_period
            $error("tick period must be at least two cycles");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             tick_ff;
    logic             nxt_tick;

    // free-running divider, one pulse per period
    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff + CNT_W'(1);
        if (cnt_ff == LAST) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;

endmodule : ear_tick_gen

// ==== test/ear_front_model.sv ====
`timescale 1ns/1ns
module ear_front_model (
    input  wire logic        decade_switch_a,
    input  wire logic        decade_switch_b,
    input  wire logic        decade_switch_c,
    input  wire logic        divide_by_ten,
    input  wire logic [31:0] ion_level,
    output logic             over_range_comparator,
    output logic             under_range_comparator
);
    import ear_pkg::*;
    int dec;
    int rd;
    // reading follows the selected decade, so ranging closes a real loop
    always_comb begin
        dec = decade_switch_c ? 4 : (decade_switch_b ? 2 : 0);
        dec = dec + (divide_by_ten ? 1 : 0);
        rd  = int'(ion_level / (32'd10 ** dec));
        // no switch closed leaves the loop open: the reading pins high
        if (!(decade_switch_a || decade_switch_b || decade_switch_c)) begin
            rd = OVER_PERMILLE + 1;
        end
        over_range_comparator  = rd > OVER_PERMILLE;
        under_range_comparator = rd < UNDER_PERMILLE;
    end
endmodule : ear_front_model

// ==== test/test_electrometer_autorange_ctrl.sv ====
`timescale 1ns/1ns
module test_electrometer_autorange_ctrl;
    import ear_pkg::*;
    // short tick keeps the run small; the ticks waits and wait_change bounds derive from it
    localparam int TK = 16;
    logic        core_clk;
    logic        sys_rst;
    logic        filament_on;
    logic        autorange_on;
    logic        over_c;
    logic        under_c;
    logic        manual_range_up;
    logic        manual_range_down;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        sw_a;
    logic        sw_b;
    logic        sw_c;
    logic        div10;
    logic [2:0]  conv_decade;
    logic        p_valid;
    logic        p_low;
    logic [31:0] ion_level;
    int          err_count;
    int          n_checks;
    int          cyc;

    ear_autorange #(.TICK_CYCLES(TK)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .filament_on(filament_on), .autorange_on(autorange_on),
        .over_range_comparator(over_c), .under_range_comparator(under_c),
        .manual_range_up(manual_range_up),
        .manual_range_down(manual_range_down),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .decade_switch_a(sw_a), .decade_switch_b(sw_b),
        .decade_switch_c(sw_c), .divide_by_ten(div10),
        .conv_decade(conv_decade), .pressure_valid(p_valid),
        .pressure_force_low(p_low)
    );

    ear_front_model i_front (
        .decade_switch_a(sw_a), .decade_switch_b(sw_b),
        .decade_switch_c(sw_c), .divide_by_ten(div10),
        .ion_level(ion_level), .over_range_comparator(over_c),
        .under_range_comparator(under_c)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic check_range(logic [2:0] r);
        logic [3:0] e;
        e[3] = r == 3'h4;
        e[2] = r == 3'h2 || r == 3'h3;
        e[1] = r < 3'h2;
        e[0] = r == 3'h1 || r == 3'h3;
        check("range", {5'h0, conv_decade}, {5'h0, r});
        check("switches", {4'h0, sw_c, sw_b, sw_a, div10}, {4'h0, e});
    endtask : check_range

    task automatic ticks(int n);
        repeat (n * TK) @(posedge core_clk);
        #1;
    endtask : ticks

    task automatic wait_change(int bound, output int n);
        logic [2:0] old;
        old = conv_decade;
        n = 0;
        while (conv_decade === old && n < bound) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : wait_change

    task automatic reg_write(logic [3:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        @(posedge core_clk);
        #1;
        check_range(3'h0);
        check("force_low", {7'h0, p_low}, 8'h01);
        reg_read(REG_STATUS, d);
        check("status", d, 8'h00);
    endtask : t_reset

    task automatic t_auto_settle();
        int n;
        logic [7:0] d;
        @(posedge core_clk);
        ion_level    <= 32'd50000;
        filament_on  <= 1'b1;
        autorange_on <= 1'b1;
        wait_change(TK + 8, n);
        check_range(3'h1);
        wait_change(TK + 8, n);
        check("tick spacing", n[7:0], TK[7:0]);
        check_range(3'h2);
        ticks(3);
        check_range(3'h2);
        check("valid", {7'h0, p_valid}, 8'h01);
        check("force_low", {7'h0, p_low}, 8'h00);
        reg_read(REG_STATUS, d);
        check("status", d, 8'h3A);
    endtask : t_auto_settle

    task automatic t_bounds();
        logic [7:0] d;
        @(posedge core_clk);
        ion_level <= 32'd100000000;
        ticks(5);
        check_range(3'h4);
        // hold freezes automatic stepping even with the signal low
        reg_write(REG_CTRL, 8'h01);
        ion_level <= 32'd10;
        ticks(3);
        check_range(3'h4);
        reg_read(REG_CTRL, d);
        check("ctrl", d, 8'h01);
        reg_write(REG_CTRL, 8'h00);
        ticks(7);
        check_range(3'h0);
    endtask : t_bounds

    task automatic t_filament_off();
        logic [7:0] d;
        @(posedge core_clk);
        filament_on <= 1'b0;
        ion_level   <= 32'd100000000;
        ticks(3);
        check_range(3'h0);
        check("valid", {7'h0, p_valid}, 8'h00);
        check("force_low", {7'h0, p_low}, 8'h01);
        reg_write(4'hC, 8'hFF);
        reg_read(4'hC, d);
        check("unmapped", d, 8'h00);
        reg_read(REG_CTRL, d);
        check("ctrl", d, 8'h00);
    endtask : t_filament_off

    task automatic t_manual();
        @(posedge core_clk);
        filament_on  <= 1'b1;
        autorange_on <= 1'b0;
        ticks(3);
        check_range(3'h0);
        check("valid", {7'h0, p_valid}, 8'h00);
        @(posedge core_clk);
        manual_range_up <= 1'b1;
        ticks(4);
        check_range(3'h1);
        @(posedge core_clk);
        manual_range_up   <= 1'b0;
        manual_range_down <= 1'b1;
        ticks(3);
        check_range(3'h0);
        @(posedge core_clk);
        manual_range_down <= 1'b0;
        reg_write(REG_STEP, 8'h01);
        ticks(2);
        check_range(3'h1);
        reg_write(REG_STEP, 8'h02);
        ticks(2);
        check_range(3'h0);
        reg_write(REG_STEP, 8'h02);
        ticks(2);
        check_range(3'h0);
    endtask : t_manual

    task automatic complete_run();
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // a hang cannot pass: the run is well under this ceiling
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        err_count = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        filament_on = 1'b0;
        autorange_on = 1'b0;
        manual_range_up = 1'b0;
        manual_range_down = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ion_level = 32'd500;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_auto_settle();
        t_bounds();
        t_filament_off();
        t_manual();
        complete_run();
    end
endmodule : test_electrometer_autorange_ctrl
